// >>> core/dtc_params.svh
// Addresses, field positions, reset values and divider counts of the dual timer block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define DTC_ADDR_RUN_FLAG   8'h88
`define DTC_ADDR_MODE       8'h89
`define DTC_ADDR_T0_LOW     8'h8A
`define DTC_ADDR_T1_LOW     8'h8B
`define DTC_ADDR_T0_HIGH    8'h8C
`define DTC_ADDR_T1_HIGH    8'h8D
`define DTC_ADDR_CLK_CTRL   8'h8E

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DTC_BIT_T1_OVF      7
`define DTC_BIT_T1_RUN      6
`define DTC_BIT_T0_OVF      5
`define DTC_BIT_T0_RUN      4
`define DTC_BIT_X1_FLAG     3
`define DTC_BIT_X1_TYPE     2
`define DTC_BIT_X0_FLAG     1
`define DTC_BIT_X0_TYPE     0
`define DTC_BIT_T1_DIV      4
`define DTC_BIT_T0_DIV      3

// ------------------------------------------------------------
// Reset values, fill values and divider counts
// ------------------------------------------------------------
`define DTC_RST_BYTE        8'h00
`define DTC_RST_BIT         1'b0
`define DTC_CLK_CTRL_FILL   8'hE7
`define DTC_UNMAPPED_READ   8'hFF
`define DTC_DIV_FAST        4'h4
`define DTC_DIV_SLOW        4'hC

`endif

// >>> core/dtc_pkg.sv
// Types shared by the dual timer block
package dtc_pkg;
    typedef enum logic [1:0] {
        DTC_MODE_PRE13,
        DTC_MODE_FULL16,
        DTC_MODE_RELOAD8,
        DTC_MODE_SPLIT8
    } dtc_mode_t;

    typedef struct packed {
        logic      gate;
        logic      ct;
        dtc_mode_t mode;
    } dtc_tmode_t;
endpackage

// >>> core/dtc_tmr_if.sv
// Link between the control logic and one timer counter
interface dtc_tmr_if;
    import dtc_pkg::*;
    dtc_mode_t   mode;
    logic        inc_lo;
    logic        inc_hi;
    logic        wr_lo;
    logic        wr_hi;
    logic [7:0]  wdata;
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
    logic        ovf_lo;
    logic        ovf_hi;

    modport ctl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
                 input  cnt_lo, cnt_hi, ovf_lo, ovf_hi);
    modport tmr (input  mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
                 output cnt_lo, cnt_hi, ovf_lo, ovf_hi);
endinterface

// >>> core/dtc_timer.sv
// One 16-bit timer counter with its four counting modes
module dtc_timer #(
    parameter bit SPLIT_OK = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    dtc_tmr_if.tmr   bus
);
    import dtc_pkg::*;
    `include "dtc_params.svh"

    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic [7:0] lo_nxt;
    logic [7:0] hi_nxt;
    logic       ovf_lo_c;
    logic       ovf_hi_c;

    // ------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------
    always_comb begin
        lo_nxt   = lo_r;
        hi_nxt   = hi_r;
        ovf_lo_c = 1'b0;
        ovf_hi_c = 1'b0;
        case (bus.mode)
            DTC_MODE_PRE13: begin
                if (bus.inc_lo) begin
                    {hi_nxt, lo_nxt[4:0]} = {hi_r, lo_r[4:0]} + 13'h0001;
                    ovf_lo_c              = &{hi_r, lo_r[4:0]};
                end
            end
            DTC_MODE_FULL16: begin
                if (bus.inc_lo) begin
                    {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h0001;
                    ovf_lo_c         = &{hi_r, lo_r};
                end
            end
            DTC_MODE_RELOAD8: begin
                if (bus.inc_lo) begin
                    if (&lo_r) begin
                        lo_nxt   = hi_r;
                        ovf_lo_c = 1'b1;
                    end else begin
                        lo_nxt = lo_r + 8'h01;
                    end
                end
            end
            DTC_MODE_SPLIT8: begin
                if (SPLIT_OK && bus.inc_lo) begin
                    lo_nxt   = lo_r + 8'h01;
                    ovf_lo_c = &lo_r;
                end
                if (SPLIT_OK && bus.inc_hi) begin
                    hi_nxt   = hi_r + 8'h01;
                    ovf_hi_c = &hi_r;
                end
            end
            default: begin
                lo_nxt = lo_r;
            end
        endcase
    end

    // Software write to a byte takes that byte's place over a count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_r <= `DTC_RST_BYTE;
            hi_r <= `DTC_RST_BYTE;
        end else begin
            lo_r <= bus.wr_lo ? bus.wdata : lo_nxt;
            hi_r <= bus.wr_hi ? bus.wdata : hi_nxt;
        end
    end

    assign bus.cnt_lo = lo_r;
    assign bus.cnt_hi = hi_r;
    assign bus.ovf_lo = ovf_lo_c;
    assign bus.ovf_hi = ovf_hi_c;
endmodule

// >>> core/dtc_top.sv
// Dual timer counter with external interrupt detect flags and register port
// Behaviour
// - Each timer overflow sets its own overflow flag, except timer 1 while timer 0 is in mode 11.
// - Vectoring to a timer's service routine clears its overflow flag.
// - Software may write overflow flags to either value.
// - Run bit starts the timer when set, stops it when clear.
// - Interrupt 1 pin edge or level sets its detect flag.
// - Interrupt 0 pin edge or level sets its detect flag.
// - Vectoring clears a detect flag only in edge mode.
// - In level mode the detect flag follows the pin.
// - Type bit picks falling edge or low level per input.
// - Gate on: count only while interrupt pin high and run bit set.
// - Gate off: count whenever run bit set.
// - Counter select clear: count internal clock ticks.
// - Counter select set: count falling edges of the count pin.
// - Mode 00: 8-bit counter behind a 5-bit prescaler.
// - Mode 01: full 16-bit counter, no prescaler.
// - Mode 10: low byte auto-reloads from high byte on overflow.
// - Timer 0 mode 11: low byte uses timer 0 controls.
// - Timer 0 mode 11: high byte counts internal ticks only.
// - Clock select 1 divides core clock by 4, 0 by 12.
module dtc_top (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       ext_irq0_pin,
    input  wire logic       ext_irq1_pin,
    input  wire logic       timer0_count_pin,
    input  wire logic       timer1_count_pin,
    input  wire logic       timer0_vector_ack,
    input  wire logic       timer1_vector_ack,
    input  wire logic       ext_irq0_vector_ack,
    input  wire logic       ext_irq1_vector_ack,
    output logic            timer0_overflow_flag,
    output logic            timer1_overflow_flag,
    output logic            ext_irq0_detect_flag,
    output logic            ext_irq1_detect_flag,
    output dtc_pkg::dtc_mode_t timer0_mode
);
    import dtc_pkg::*;
    `include "dtc_params.svh"

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic       timer0_overflow_flag_r;
    logic       timer1_overflow_flag_r;
    logic       timer0_run_r;
    logic       timer1_run_r;
    logic       ext_irq0_detect_flag_r;
    logic       ext_irq1_detect_flag_r;
    logic       ext_irq0_trigger_type_r;
    logic       ext_irq1_trigger_type_r;
    logic [7:0] timer_mode_control_r;
    logic       timer0_clock_divider_select_r;
    logic       timer1_clock_divider_select_r;
    logic [3:0] div0_r;
    logic [3:0] div1_r;
    logic       irq0_pin_d_r;
    logic       irq1_pin_d_r;
    logic       cnt0_pin_d_r;
    logic       cnt1_pin_d_r;
    logic [7:0] sfr_rdata_r;
    logic [7:0] rdata_nxt;

    dtc_tmode_t t0_cfg;
    dtc_tmode_t t1_cfg;
    logic       tick0;
    logic       tick1;
    logic       t0_split;
    logic       wr_run_flag;
    logic       wr_mode;
    logic       wr_clk_ctrl;
    logic       irq0_fell;
    logic       irq1_fell;
    logic       t1_ovf_event;

    dtc_tmr_if t0_bus ();
    dtc_tmr_if t1_bus ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Divide by 4 or 12
    function automatic logic div_done(input logic [3:0] cnt, input logic fast);
        logic [3:0] last;
        last     = (fast ? `DTC_DIV_FAST : `DTC_DIV_SLOW) - 4'h1;
        div_done = (cnt >= last);
    endfunction

    function automatic logic [3:0] div_step(input logic [3:0] cnt, input logic fast);
        div_step = div_done(cnt, fast) ? 4'h0 : cnt + 4'h1;
    endfunction

    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    function automatic logic run_gate(input logic run, input logic gate, input logic pin);
        run_gate = run & (~gate | pin);
    endfunction

    function automatic logic pick_source(input logic ct, input logic edge_seen,
                                         input logic tick);
        pick_source = ct ? edge_seen : tick;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign t0_cfg      = dtc_tmode_t'(timer_mode_control_r[3:0]);
    assign t1_cfg      = dtc_tmode_t'(timer_mode_control_r[7:4]);
    assign t0_split    = (t0_cfg.mode == DTC_MODE_SPLIT8);
    assign wr_run_flag = sfr_wr && (sfr_addr == `DTC_ADDR_RUN_FLAG);
    assign wr_mode     = sfr_wr && (sfr_addr == `DTC_ADDR_MODE);
    assign wr_clk_ctrl = sfr_wr && (sfr_addr == `DTC_ADDR_CLK_CTRL);
    assign tick0       = div_done(div0_r, timer0_clock_divider_select_r);
    assign tick1       = div_done(div1_r, timer1_clock_divider_select_r);
    assign irq0_fell   = fell(irq0_pin_d_r, ext_irq0_pin);
    assign irq1_fell   = fell(irq1_pin_d_r, ext_irq1_pin);

    // ------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------
    // Free-running so a timer started mid-period sees its first tick early
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div0_r <= 4'h0;
            div1_r <= 4'h0;
        end else begin
            div0_r <= div_step(div0_r, timer0_clock_divider_select_r);
            div1_r <= div_step(div1_r, timer1_clock_divider_select_r);
        end
    end

    // ------------------------------------------------------------
    // Pin history for edge detection
    // ------------------------------------------------------------
    // Resets high so a pin held low at release is taken as a falling edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq0_pin_d_r <= 1'b1;
            irq1_pin_d_r <= 1'b1;
            cnt0_pin_d_r <= 1'b1;
            cnt1_pin_d_r <= 1'b1;
        end else begin
            irq0_pin_d_r <= ext_irq0_pin;
            irq1_pin_d_r <= ext_irq1_pin;
            cnt0_pin_d_r <= timer0_count_pin;
            cnt1_pin_d_r <= timer1_count_pin;
        end
    end

    // ------------------------------------------------------------
    // Timer links
    // ------------------------------------------------------------
    // Run bit enables counting
    assign t0_bus.inc_lo = run_gate(timer0_run_r, t0_cfg.gate, ext_irq0_pin)
                         & pick_source(t0_cfg.ct, fell(cnt0_pin_d_r, timer0_count_pin),
                                       tick0);
    assign t0_bus.inc_hi = t0_split & timer1_run_r & tick0;
    assign t0_bus.mode   = t0_cfg.mode;
    assign t0_bus.wr_lo  = sfr_wr && (sfr_addr == `DTC_ADDR_T0_LOW);
    assign t0_bus.wr_hi  = sfr_wr && (sfr_addr == `DTC_ADDR_T0_HIGH);
    assign t0_bus.wdata  = sfr_wdata;

    assign t1_bus.inc_lo = run_gate(timer1_run_r, t1_cfg.gate, ext_irq1_pin)
                         & pick_source(t1_cfg.ct, fell(cnt1_pin_d_r, timer1_count_pin),
                                       tick1);
    assign t1_bus.inc_hi = 1'b0;
    assign t1_bus.mode   = t1_cfg.mode;
    assign t1_bus.wr_lo  = sfr_wr && (sfr_addr == `DTC_ADDR_T1_LOW);
    assign t1_bus.wr_hi  = sfr_wr && (sfr_addr == `DTC_ADDR_T1_HIGH);
    assign t1_bus.wdata  = sfr_wdata;

    dtc_timer #(
        .SPLIT_OK (1'b1)
    ) u_timer0 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (t0_bus)
    );

    // Timer 1 has no split mode; it holds its count in mode 11
    dtc_timer #(
        .SPLIT_OK (1'b0)
    ) u_timer1 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (t1_bus)
    );

    // While timer 0 is split its high byte owns the timer 1 flag
    assign t1_ovf_event = t0_split ? t0_bus.ovf_hi : t1_bus.ovf_lo;

    // ------------------------------------------------------------
    // Overflow flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer0_overflow_flag_r <= `DTC_RST_BIT;
        end else if (t0_bus.ovf_lo) begin
            timer0_overflow_flag_r <= 1'b1;
        end else if (wr_run_flag) begin
            timer0_overflow_flag_r <= sfr_wdata[`DTC_BIT_T0_OVF];
        end else if (timer0_vector_ack) begin
            timer0_overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer1_overflow_flag_r <= `DTC_RST_BIT;
        end else if (t1_ovf_event) begin
            timer1_overflow_flag_r <= 1'b1;
        end else if (wr_run_flag) begin
            timer1_overflow_flag_r <= sfr_wdata[`DTC_BIT_T1_OVF];
        end else if (timer1_vector_ack) begin
            timer1_overflow_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Run and trigger type bits
    // ------------------------------------------------------------
    // Software run control
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer0_run_r            <= `DTC_RST_BIT;
            timer1_run_r            <= `DTC_RST_BIT;
            ext_irq0_trigger_type_r <= `DTC_RST_BIT;
            ext_irq1_trigger_type_r <= `DTC_RST_BIT;
        end else if (wr_run_flag) begin
            timer0_run_r            <= sfr_wdata[`DTC_BIT_T0_RUN];
            timer1_run_r            <= sfr_wdata[`DTC_BIT_T1_RUN];
            ext_irq0_trigger_type_r <= sfr_wdata[`DTC_BIT_X0_TYPE];
            ext_irq1_trigger_type_r <= sfr_wdata[`DTC_BIT_X1_TYPE];
        end
    end

    // ------------------------------------------------------------
    // External interrupt detect flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_irq0_detect_flag_r <= `DTC_RST_BIT;
        end else if (!ext_irq0_trigger_type_r) begin
            ext_irq0_detect_flag_r <= ~ext_irq0_pin;
        end else if (irq0_fell) begin
            ext_irq0_detect_flag_r <= 1'b1;
        end else if (wr_run_flag) begin
            ext_irq0_detect_flag_r <= sfr_wdata[`DTC_BIT_X0_FLAG];
        end else if (ext_irq0_vector_ack) begin
            ext_irq0_detect_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_irq1_detect_flag_r <= `DTC_RST_BIT;
        end else if (!ext_irq1_trigger_type_r) begin
            ext_irq1_detect_flag_r <= ~ext_irq1_pin;
        end else if (irq1_fell) begin
            ext_irq1_detect_flag_r <= 1'b1;
        end else if (wr_run_flag) begin
            ext_irq1_detect_flag_r <= sfr_wdata[`DTC_BIT_X1_FLAG];
        end else if (ext_irq1_vector_ack) begin
            ext_irq1_detect_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode and clock select registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_mode_control_r <= `DTC_RST_BYTE;
        end else if (wr_mode) begin
            timer_mode_control_r <= sfr_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer0_clock_divider_select_r <= `DTC_RST_BIT;
            timer1_clock_divider_select_r <= `DTC_RST_BIT;
        end else if (wr_clk_ctrl) begin
            timer0_clock_divider_select_r <= sfr_wdata[`DTC_BIT_T0_DIV];
            timer1_clock_divider_select_r <= sfr_wdata[`DTC_BIT_T1_DIV];
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = `DTC_UNMAPPED_READ;
        case (sfr_addr)
            `DTC_ADDR_RUN_FLAG: begin
                rdata_nxt = {timer1_overflow_flag_r, timer1_run_r,
                             timer0_overflow_flag_r, timer0_run_r,
                             ext_irq1_detect_flag_r, ext_irq1_trigger_type_r,
                             ext_irq0_detect_flag_r, ext_irq0_trigger_type_r};
            end
            `DTC_ADDR_MODE:    rdata_nxt = timer_mode_control_r;
            `DTC_ADDR_T0_LOW:  rdata_nxt = t0_bus.cnt_lo;
            `DTC_ADDR_T1_LOW:  rdata_nxt = t1_bus.cnt_lo;
            `DTC_ADDR_T0_HIGH: rdata_nxt = t0_bus.cnt_hi;
            `DTC_ADDR_T1_HIGH: rdata_nxt = t1_bus.cnt_hi;
            `DTC_ADDR_CLK_CTRL: begin
                // Bits owned by other blocks read high
                rdata_nxt = `DTC_CLK_CTRL_FILL;
                rdata_nxt[`DTC_BIT_T0_DIV] = timer0_clock_divider_select_r;
                rdata_nxt[`DTC_BIT_T1_DIV] = timer1_clock_divider_select_r;
            end
            default: rdata_nxt = `DTC_UNMAPPED_READ;
        endcase
    end

    // Read data is captured and held until the next read strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata_r <= `DTC_RST_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfr_rdata            = sfr_rdata_r;
    assign timer0_overflow_flag = timer0_overflow_flag_r;
    assign timer1_overflow_flag = timer1_overflow_flag_r;
    assign ext_irq0_detect_flag = ext_irq0_detect_flag_r;
    assign ext_irq1_detect_flag = ext_irq1_detect_flag_r;
    assign timer0_mode          = dtc_mode_t'(timer_mode_control_r[1:0]);
endmodule

// >>> bench/dtc_pin_model.sv
// Behavioural source of falling edges on a timer count pin
module dtc_pin_model (
    input wire logic clk_sys,
    output logic     pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle high, so only commanded pulses give falling edges
    initial pin = 1'b1;
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            pin <= 1'b0;
            @(posedge clk_sys);
            pin <= 1'b1;
        end
    endtask
endmodule

// >>> bench/dtc_checker.sv
// Assertion checker on the dual timer register port and flags
`include "dtc_params.svh"
module dtc_checker (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic [7:0]         sfr_addr,
    input wire logic               sfr_wr,
    input wire logic               sfr_rd,
    input wire logic [7:0]         sfr_wdata,
    input wire logic [7:0]         sfr_rdata,
    input wire logic               ext_irq0_pin,
    input wire logic               ext_irq0_vector_ack,
    input wire logic               timer0_vector_ack,
    input wire logic               ext_irq0_detect_flag,
    input wire logic               timer0_overflow_flag,
    input wire dtc_pkg::dtc_mode_t timer0_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import dtc_pkg::*;
    logic it0_r;
    logic tr0_r;
    wire  wr_ctl = sfr_wr && sfr_addr == `DTC_ADDR_RUN_FLAG;
    wire  wr_mod = sfr_wr && sfr_addr == `DTC_ADDR_MODE;
    // Shadow of type and run bits, which are not visible at the ports
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            it0_r <= 1'b0;
            tr0_r <= 1'b0;
        end else if (wr_ctl) begin
            it0_r <= sfr_wdata[`DTC_BIT_X0_TYPE];
            tr0_r <= sfr_wdata[`DTC_BIT_T0_RUN];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_level_track: assert property (
        !it0_r ##1 !it0_r |-> ext_irq0_detect_flag == !$past(ext_irq0_pin))
        else $error("level flag does not follow pin");
    a_edge_set: assert property (
        it0_r && $past(ext_irq0_pin) && !ext_irq0_pin |-> ##[1:2] ext_irq0_detect_flag)
        else $error("falling edge did not set detect flag");
    a_edge_ack: assert property (
        it0_r && ext_irq0_vector_ack && !wr_ctl && ext_irq0_pin && $past(ext_irq0_pin)
        && $past(ext_irq0_pin, 2) |=> !ext_irq0_detect_flag)
        else $error("ack did not clear edge flag");
    a_tf_ack: assert property (
        timer0_vector_ack && !tr0_r && !wr_ctl |=> !timer0_overflow_flag)
        else $error("ack did not clear overflow flag");
    a_tf_write: assert property (
        wr_ctl && !tr0_r && !timer0_vector_ack
        |=> timer0_overflow_flag == $past(sfr_wdata[`DTC_BIT_T0_OVF]))
        else $error("overflow flag write lost");
    a_tf_hold: assert property (
        timer0_overflow_flag && !timer0_vector_ack && !wr_ctl |=> timer0_overflow_flag)
        else $error("overflow flag dropped by itself");
    a_mode_write: assert property (
        wr_mod |=> timer0_mode == $past(sfr_wdata[1:0]))
        else $error("mode field not taken");
    a_mode_read: assert property (
        sfr_rd && sfr_addr == `DTC_ADDR_MODE |=> sfr_rdata[1:0] == $past(timer0_mode))
        else $error("mode readback wrong");
endmodule
bind dtc_top dtc_checker i_dtc_checker (.clk_sys, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .ext_irq0_pin, .ext_irq0_vector_ack, .timer0_vector_ack,
    .ext_irq0_detect_flag, .timer0_overflow_flag, .timer0_mode);

// >>> bench/testbench.sv
// Self-checking bench for the dual timer block
`include "dtc_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dtc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [1:0] irq_pin = 2'b11;
    logic [3:0] ack_v = 4'h0;
    logic       cnt_pin;
    logic       tf0;
    logic [2:0] fl;
    dtc_mode_t  t0_mode;
    logic       rd_p = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] r;
    logic [7:0] ra[8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90};
    logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE7, 8'hFF};
    int         n_errors = 0;
    int         total_checks = 0;
    int         cyc = 0;
    initial forever #12.5 clk_sys = ~clk_sys;
    dtc_pin_model i_dtc_pin_model (.clk_sys(clk_sys), .pin(cnt_pin));
    dtc_top i_dtc_top (.clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .ext_irq0_pin(irq_pin[0]), .ext_irq1_pin(irq_pin[1]), .timer0_count_pin(cnt_pin),
        .timer1_count_pin(cnt_pin), .timer0_vector_ack(ack_v[0]), .timer1_vector_ack(ack_v[1]),
        .ext_irq0_vector_ack(ack_v[2]), .ext_irq1_vector_ack(ack_v[3]),
        .timer0_overflow_flag(tf0), .timer1_overflow_flag(fl[0]), .ext_irq0_detect_flag(fl[1]),
        .ext_irq1_detect_flag(fl[2]), .timer0_mode(t0_mode));
    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    // Each access leaves one idle edge so a strobe is never driven twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic ack(input logic [3:0] v);
        ack_v <= v;
        @(posedge clk_sys);
        ack_v <= 4'h0;
        @(posedge clk_sys);
    endtask
    task automatic chk_tf(input logic e);
        @(negedge clk_sys);
        cmp1(tf0, e);
        @(posedge clk_sys);
    endtask
    // Run timer 0 until it wraps, stop it, then acknowledge the flag
    task automatic run_wrap(input int n);
        wr(`DTC_ADDR_RUN_FLAG, 8'h10);
        for (int i = 0; i < n && tf0 !== 1'b1; i++) @(negedge clk_sys);
        cmp1(tf0, 1'b1);
        @(posedge clk_sys);
        wr(`DTC_ADDR_RUN_FLAG, 8'h20);
        ack(4'h1);
        chk_tf(1'b0);
    endtask
    // Read data lands one cycle after the strobe
    always @(negedge clk_sys) begin
        if (rd_p) cmp8(sfr_rdata, exp_q.pop_front());
        rd_p = sfr_rd;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(45581));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rv[i]);
        end
        for (int m = 0; m < 4; m++) begin
            r = {4'($urandom), 2'b00, 2'(m)};
            wr(`DTC_ADDR_MODE, r);
            rd(`DTC_ADDR_MODE, r);
            cmp1(t0_mode === dtc_mode_t'(m), 1'b1);
            r = 8'($urandom);
            wr(`DTC_ADDR_T1_LOW, r);
            rd(`DTC_ADDR_T1_LOW, r);
        end
        irq_pin <= 2'b00;
        wr(`DTC_ADDR_MODE, 8'h01);
        wr(`DTC_ADDR_CLK_CTRL, 8'h08);
        rd(`DTC_ADDR_CLK_CTRL, 8'hEF);
        wr(`DTC_ADDR_T0_LOW, 8'hFF);
        wr(`DTC_ADDR_T0_HIGH, 8'hFF);
        run_wrap(8);
        rd(`DTC_ADDR_T0_LOW, 8'h00);
        rd(`DTC_ADDR_T0_HIGH, 8'h00);
        wr(`DTC_ADDR_RUN_FLAG, 8'hA0);
        chk_tf(1'b1);
        cmp8(8'(fl), 8'h07);
        wr(`DTC_ADDR_RUN_FLAG, 8'h00);
        chk_tf(1'b0);
        r = 8'($urandom);
        wr(`DTC_ADDR_MODE, 8'h02);
        wr(`DTC_ADDR_CLK_CTRL, 8'h00);
        wr(`DTC_ADDR_T0_HIGH, r);
        wr(`DTC_ADDR_T0_LOW, 8'hFF);
        run_wrap(16);
        rd(`DTC_ADDR_T0_LOW, r);
        r = {3'($urandom), 5'h1F};
        wr(`DTC_ADDR_MODE, 8'h00);
        wr(`DTC_ADDR_CLK_CTRL, 8'h08);
        wr(`DTC_ADDR_T0_LOW, r);
        wr(`DTC_ADDR_T0_HIGH, 8'hFF);
        run_wrap(8);
        rd(`DTC_ADDR_T0_LOW, {r[7:5], 5'h00});
        rd(`DTC_ADDR_T0_HIGH, 8'h00);
        wr(`DTC_ADDR_MODE, 8'h0D);
        wr(`DTC_ADDR_T0_LOW, 8'h00);
        irq_pin <= 2'b10;
        wr(`DTC_ADDR_RUN_FLAG, 8'h10);
        i_dtc_pin_model.pulse(3);
        rd(`DTC_ADDR_RUN_FLAG, 8'h12);
        irq_pin <= 2'b11;
        i_dtc_pin_model.pulse(3);
        wr(`DTC_ADDR_RUN_FLAG, 8'h00);
        rd(`DTC_ADDR_T0_LOW, 8'h03);
        wr(`DTC_ADDR_RUN_FLAG, 8'h05);
        irq_pin <= 2'b00;
        repeat (3) @(posedge clk_sys);
        irq_pin <= 2'b11;
        rd(`DTC_ADDR_RUN_FLAG, 8'h0F);
        cmp8(8'(fl), 8'h06);
        ack(4'hC);
        rd(`DTC_ADDR_RUN_FLAG, 8'h05);
        cmp8(8'(fl), 8'h00);
        repeat (3) @(posedge clk_sys);
        end_sim();
    end
endmodule
